//--- src/pqs_pkg.sv
// Constants for the P/Q/S general-purpose pin block
// Function
// - Pin input registers read pins, ignore writes
// - Data read: output bit if output, else pin; code selects by the direction bit alone, ignoring PWM and fault overrides
// - Direction 0 input, 1 output
// - Port P direction covers six pins
// - Enabled PWM channel forces its pin output
// - Disabled PWM channel returns control to direction
// - Port Q direction covers seven pins
// - Enabled fault/status function forces pin input
// - Q pins feed fault and status inputs
// - Reduced-drive bit selects one-third drive strength
// - Reduced drive ignored on input pins
// - Pull-enable bit switches input pull device
// - Pull enable ignored on output pins
// - Polarity 0 pull-up, 1 pull-down
// - Polarity only matters for pulled inputs
// - Q and S pins reset as high-impedance inputs
// - SPI owns S pins 7..4, top priority
// - Second serial interface owns S pins 3,2
// - First serial interface owns S pins 1,0
// - P pins reset as high-impedance inputs
package pqs_pkg;
	localparam int P_WIDTH = 6;
	localparam int Q_WIDTH = 7;
	localparam int S_WIDTH = 8;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int SYNC_STAGES = 3;

	localparam logic [ADDR_W-1:0] P_DATA_OFF = 8'h00;
	localparam logic [ADDR_W-1:0] P_PIN_INPUT_OFF = 8'h04;
	localparam logic [ADDR_W-1:0] P_DIRECTION_OFF = 8'h08;
	localparam logic [ADDR_W-1:0] P_DRIVE_STRENGTH_OFF = 8'h0c;
	localparam logic [ADDR_W-1:0] P_PULL_ENABLE_OFF = 8'h10;
	localparam logic [ADDR_W-1:0] P_PULL_POLARITY_OFF = 8'h14;
	localparam logic [ADDR_W-1:0] Q_DATA_OFF = 8'h20;
	localparam logic [ADDR_W-1:0] Q_PIN_INPUT_OFF = 8'h24;
	localparam logic [ADDR_W-1:0] Q_DIRECTION_OFF = 8'h28;
	localparam logic [ADDR_W-1:0] Q_DRIVE_STRENGTH_OFF = 8'h2c;
	localparam logic [ADDR_W-1:0] Q_PULL_ENABLE_OFF = 8'h30;
	localparam logic [ADDR_W-1:0] Q_PULL_POLARITY_OFF = 8'h34;
	localparam logic [ADDR_W-1:0] S_DATA_OFF = 8'h40;
	localparam logic [ADDR_W-1:0] S_PIN_INPUT_OFF = 8'h44;
	localparam logic [ADDR_W-1:0] S_DIRECTION_OFF = 8'h48;

	// Everything resets to zero: inputs, no pulls, full drive
	localparam logic [7:0] REG_RESET = 8'h00;

	// Port S pin positions
	localparam int S_SPI_LO = 4;
	localparam int S_B_TX = 3;
	localparam int S_B_RX = 2;
	localparam int S_A_TX = 1;
	localparam int S_A_RX = 0;
endpackage : pqs_pkg

//--- src/pqs_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pqs_pin_sync #(
	parameter int WIDTH = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] level
);
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			logic s1;
			logic s2;
			logic s3;
			// First stage is read only by the second
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					s1 <= 1'b0;
					s2 <= 1'b0;
					s3 <= 1'b0;
				end else begin
					s1 <= pin_in[i];
					s2 <= s1;
					s3 <= s2;
				end
			end
			// A change counts only once stages two and three agree
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					level[i] <= 1'b0;
				end else if (s2 == s3) begin
					level[i] <= s3;
				end
			end
		end
	endgenerate
endmodule : pqs_pin_sync
`default_nettype wire

//--- src/pqs_gpio.sv
// General-purpose pin block for ports P, Q and S with peripheral override
`timescale 1ns/1ps
`default_nettype none
module pqs_gpio #(
	parameter int PW = pqs_pkg::P_WIDTH,
	parameter int QW = pqs_pkg::Q_WIDTH,
	parameter int SW = pqs_pkg::S_WIDTH
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [pqs_pkg::ADDR_W-1:0] paddr,
	input wire logic [pqs_pkg::DATA_W-1:0] pwdata,
	output logic [pqs_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [PW-1:0] pwm_side_pins_in,
	output logic [PW-1:0] pwm_side_pins_out,
	output logic [PW-1:0] pwm_side_pins_oe,
	output logic [PW-1:0] pwm_pins_low_drive,
	output logic [PW-1:0] pwm_pins_pull_en,
	output logic [PW-1:0] pwm_pins_pull_sel,
	input wire logic [QW-1:0] fault_side_pins_in,
	output logic [QW-1:0] fault_side_pins_out,
	output logic [QW-1:0] fault_side_pins_oe,
	output logic [QW-1:0] fault_pins_low_drive,
	output logic [QW-1:0] fault_pins_pull_en,
	output logic [QW-1:0] fault_pins_pull_sel,
	input wire logic [SW-1:0] serial_side_pins_in,
	output logic [SW-1:0] serial_side_pins_out,
	output logic [SW-1:0] serial_side_pins_oe,
	input wire logic [PW-1:0] pwm_chan_en,
	input wire logic [PW-1:0] pwm_chan_out,
	input wire logic [QW-1:0] fault_fn_en,
	output logic [3:0] fault_inputs,
	output logic [2:0] current_status_inputs_n,
	input wire logic spi_en,
	input wire logic [3:0] spi_pin_out,
	input wire logic [3:0] spi_pin_oe,
	output logic [3:0] spi_pin_in,
	input wire logic serial_b_tx_en,
	input wire logic serial_b_rx_en,
	input wire logic serial_b_tx,
	output logic serial_b_rx,
	input wire logic serial_a_tx_en,
	input wire logic serial_a_rx_en,
	input wire logic serial_a_tx,
	output logic serial_a_rx
);
	import pqs_pkg::*;

	logic [PW-1:0] p_data, p_dir, p_drv, p_pe, p_ps, p_pin;
	logic [QW-1:0] q_data, q_dir, q_drv, q_pe, q_ps, q_pin;
	logic [SW-1:0] s_data, s_dir, s_pin;
	logic setup_rd;
	logic wr_take;
	logic [DATA_W-1:0] next_rdata;
	logic next_err;
	logic [PW-1:0] next_p_oe;
	logic [QW-1:0] next_q_oe;
	logic [SW-1:0] next_s_oe, next_s_out;

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
		return a == off;
	endfunction : hit

	function automatic logic [DATA_W-1:0] zx(input logic [7:0] v);
		return {{(DATA_W-8){1'b0}}, v};
	endfunction : zx

	// Pins come from outside the clock domain
	pqs_pin_sync #(.WIDTH(PW)) u_sync_p (
		.clk(clk),
		.rst_n(rst_n),
		.pin_in(pwm_side_pins_in),
		.level(p_pin)
	);
	pqs_pin_sync #(.WIDTH(QW)) u_sync_q (
		.clk(clk),
		.rst_n(rst_n),
		.pin_in(fault_side_pins_in),
		.level(q_pin)
	);
	pqs_pin_sync #(.WIDTH(SW)) u_sync_s (
		.clk(clk),
		.rst_n(rst_n),
		.pin_in(serial_side_pins_in),
		.level(s_pin)
	);

	assign setup_rd = psel && !penable;
	// Writes land only at the edge where the master sees pready
	assign wr_take = psel && penable && pready && pwrite;

	// Read mux; data registers show the pin while its direction bit is 0
	always_comb begin
		next_rdata = '0;
		next_err = 1'b0;
		case (paddr)
			P_DATA_OFF: next_rdata = zx(8'((p_dir & p_data) | (~p_dir & p_pin)));
			P_PIN_INPUT_OFF: next_rdata = zx(8'(p_pin));
			P_DIRECTION_OFF: next_rdata = zx(8'(p_dir));
			P_DRIVE_STRENGTH_OFF: next_rdata = zx(8'(p_drv));
			P_PULL_ENABLE_OFF: next_rdata = zx(8'(p_pe));
			P_PULL_POLARITY_OFF: next_rdata = zx(8'(p_ps));
			Q_DATA_OFF: next_rdata = zx(8'((q_dir & q_data) | (~q_dir & q_pin)));
			Q_PIN_INPUT_OFF: next_rdata = zx(8'(q_pin));
			Q_DIRECTION_OFF: next_rdata = zx(8'(q_dir));
			Q_DRIVE_STRENGTH_OFF: next_rdata = zx(8'(q_drv));
			Q_PULL_ENABLE_OFF: next_rdata = zx(8'(q_pe));
			Q_PULL_POLARITY_OFF: next_rdata = zx(8'(q_ps));
			S_DATA_OFF: next_rdata = zx(8'((s_dir & s_data) | (~s_dir & s_pin)));
			S_PIN_INPUT_OFF: next_rdata = zx(8'(s_pin));
			S_DIRECTION_OFF: next_rdata = zx(8'(s_dir));
			default: next_err = 1'b1;
		endcase
	end

	// One wait-free access phase: answer is prepared during setup
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else begin
			pready <= setup_rd;
			pslverr <= setup_rd && next_err;
			if (setup_rd && !pwrite) begin
				prdata <= next_rdata;
			end
		end
	end

	// Pin input offsets have no write branch, so writes there are dropped
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			p_data <= PW'(REG_RESET);
			p_dir <= PW'(REG_RESET);
			p_drv <= PW'(REG_RESET);
			p_pe <= PW'(REG_RESET);
			p_ps <= PW'(REG_RESET);
		end else if (wr_take) begin
			// Upper write bits beyond the port width are dropped
			if (hit(paddr, P_DATA_OFF)) p_data <= pwdata[PW-1:0];
			if (hit(paddr, P_DIRECTION_OFF)) p_dir <= pwdata[PW-1:0];
			if (hit(paddr, P_DRIVE_STRENGTH_OFF)) p_drv <= pwdata[PW-1:0];
			if (hit(paddr, P_PULL_ENABLE_OFF)) p_pe <= pwdata[PW-1:0];
			if (hit(paddr, P_PULL_POLARITY_OFF)) p_ps <= pwdata[PW-1:0];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q_data <= QW'(REG_RESET);
			q_dir <= QW'(REG_RESET);
			q_drv <= QW'(REG_RESET);
			q_pe <= QW'(REG_RESET);
			q_ps <= QW'(REG_RESET);
		end else if (wr_take) begin
			if (hit(paddr, Q_DATA_OFF)) q_data <= pwdata[QW-1:0];
			if (hit(paddr, Q_DIRECTION_OFF)) q_dir <= pwdata[QW-1:0];
			if (hit(paddr, Q_DRIVE_STRENGTH_OFF)) q_drv <= pwdata[QW-1:0];
			if (hit(paddr, Q_PULL_ENABLE_OFF)) q_pe <= pwdata[QW-1:0];
			if (hit(paddr, Q_PULL_POLARITY_OFF)) q_ps <= pwdata[QW-1:0];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_data <= SW'(REG_RESET);
			s_dir <= SW'(REG_RESET);
		end else if (wr_take) begin
			if (hit(paddr, S_DATA_OFF)) s_data <= pwdata[SW-1:0];
			if (hit(paddr, S_DIRECTION_OFF)) s_dir <= pwdata[SW-1:0];
		end
	end

	// Peripherals override direction; the register bits are left untouched
	assign next_p_oe = pwm_chan_en | p_dir;
	assign next_q_oe = q_dir & ~fault_fn_en;

	always_comb begin
		next_s_oe = s_dir;
		next_s_out = s_data;
		// Serial interfaces first, SPI last so that it wins
		if (serial_a_rx_en) next_s_oe[S_A_RX] = 1'b0;
		if (serial_a_tx_en) begin
			next_s_oe[S_A_TX] = 1'b1;
			next_s_out[S_A_TX] = serial_a_tx;
		end
		if (serial_b_rx_en) next_s_oe[S_B_RX] = 1'b0;
		if (serial_b_tx_en) begin
			next_s_oe[S_B_TX] = 1'b1;
			next_s_out[S_B_TX] = serial_b_tx;
		end
		if (spi_en) begin
			next_s_oe[SW-1:S_SPI_LO] = spi_pin_oe;
			next_s_out[SW-1:S_SPI_LO] = spi_pin_out;
		end
	end

	// Pad controls are registered so every output comes from a flop
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pwm_side_pins_out <= '0;
			pwm_side_pins_oe <= '0;
			pwm_pins_low_drive <= '0;
			pwm_pins_pull_en <= '0;
			pwm_pins_pull_sel <= '0;
		end else begin
			pwm_side_pins_out <= (pwm_chan_en & pwm_chan_out) | (~pwm_chan_en & p_data);
			pwm_side_pins_oe <= next_p_oe;
			pwm_pins_low_drive <= p_drv & next_p_oe;
			pwm_pins_pull_en <= p_pe & ~next_p_oe;
			pwm_pins_pull_sel <= p_ps & p_pe & ~next_p_oe;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fault_side_pins_out <= '0;
			fault_side_pins_oe <= '0;
			fault_pins_low_drive <= '0;
			fault_pins_pull_en <= '0;
			fault_pins_pull_sel <= '0;
		end else begin
			fault_side_pins_out <= q_data;
			fault_side_pins_oe <= next_q_oe;
			fault_pins_low_drive <= q_drv & next_q_oe;
			fault_pins_pull_en <= q_pe & ~next_q_oe;
			fault_pins_pull_sel <= q_ps & q_pe & ~next_q_oe;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			serial_side_pins_out <= '0;
			serial_side_pins_oe <= '0;
		end else begin
			serial_side_pins_out <= next_s_out;
			serial_side_pins_oe <= next_s_oe;
		end
	end

	// Peripheral inputs straight from the filtered pin levels
	assign fault_inputs = q_pin[3:0];
	assign current_status_inputs_n = q_pin[6:4];
	assign spi_pin_in = s_pin[SW-1:S_SPI_LO];
	assign serial_b_rx = s_pin[S_B_RX];
	assign serial_a_rx = s_pin[S_A_RX];

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence rd_setup(logic [ADDR_W-1:0] off);
		psel && !penable && !pwrite && paddr == off;
	endsequence
	sequence access_done;
		psel && penable && pready;
	endsequence

	AST_PIN_READ: assert property (rd_setup(P_PIN_INPUT_OFF) ##1 access_done
		|-> prdata == zx(8'($past(p_pin)))) else $error("pin input read wrong");
	AST_DATA_READ: assert property (rd_setup(Q_DATA_OFF) |=>
		prdata[QW-1:0] == $past((q_dir & q_data) | (~q_dir & q_pin))) else $error("data read wrong");
	AST_PWM_FORCE: assert property (##1 (pwm_side_pins_oe & $past(pwm_chan_en))
		== $past(pwm_chan_en)) else $error("pwm pin not forced out");
	AST_PWM_DIR: assert property (##1 pwm_side_pins_oe == $past(pwm_chan_en | p_dir))
		else $error("pwm pin direction wrong");
	AST_FAULT_IN: assert property (##1 (fault_side_pins_oe & $past(fault_fn_en)) == '0)
		else $error("fault pin not forced input");
	AST_LOW_DRIVE: assert property ((pwm_pins_low_drive & ~pwm_side_pins_oe) == '0)
		else $error("reduced drive on input");
	AST_PULL_OUT: assert property ((fault_pins_pull_en & fault_side_pins_oe) == '0)
		else $error("pull on output pin");
	AST_PULL_SEL: assert property ((fault_pins_pull_sel & ~fault_pins_pull_en) == '0)
		else $error("pull select without pull");
	AST_SPI_OWN: assert property (spi_en |=> serial_side_pins_oe[SW-1:S_SPI_LO]
		== $past(spi_pin_oe)) else $error("spi does not own pins");
	AST_UPPER_ZERO: assert property (access_done |-> prdata[DATA_W-1:8] == '0)
		else $error("upper read bits nonzero");
	AST_WRITE_ONCE: assert property (psel && !penable && pwrite && paddr == P_DIRECTION_OFF
		##1 access_done |=> p_dir == $past(pwdata[PW-1:0])) else $error("dir write lost");
endmodule : pqs_gpio
`default_nettype wire

//--- dv/pqs_pin_model.sv
// Pin pad model: resolves pin levels from block drive, far-side drive and pulls
`timescale 1ns/1ps
`default_nettype none
module pqs_pin_model #(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic [W-1:0] out,
	input wire logic [W-1:0] oe,
	input wire logic [W-1:0] pull_en,
	input wire logic [W-1:0] pull_sel,
	input wire logic [W-1:0] ext_en,
	input wire logic [W-1:0] ext_val,
	output logic [W-1:0] level
);
	logic [W-1:0] noise;
	// A floating pin must not look like a stable value
	initial begin
		noise = '0;
		forever @(posedge clk) noise <= ~noise;
	end
	always_comb begin
		for (int i = 0; i < W; i++) begin
			if (oe[i]) begin
				level[i] = out[i];
			end else if (ext_en[i]) begin
				level[i] = ext_val[i];
			end else if (pull_en[i]) begin
				level[i] = ~pull_sel[i];
			end else begin
				level[i] = noise[i];
			end
		end
	end
endmodule : pqs_pin_model
`default_nettype wire

//--- dv/testbench.sv
// Self-checking bench for the P/Q/S pin block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import pqs_pkg::*;
	logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [5:0] p_in, p_out, p_oe, p_ld, p_pe, p_ps, pwm_en, pwm_out, p_xe, p_xv;
	logic [6:0] q_in, q_out, q_oe, q_ld, q_pe, q_ps, f_en, q_xe, q_xv;
	logic [7:0] s_in, s_out, s_oe, s_xe, s_xv;
	logic [3:0] f_in, spi_out, spi_oe, spi_in;
	logic [2:0] cs_n;
	logic spi_en, b_txe, b_rxe, b_tx, b_rx, a_txe, a_rxe, a_tx, a_rx;
	int n_fail, n_compared;
	pqs_gpio i_pqs_gpio (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pwm_side_pins_in(p_in), .pwm_side_pins_out(p_out),
		.pwm_side_pins_oe(p_oe), .pwm_pins_low_drive(p_ld), .pwm_pins_pull_en(p_pe),
		.pwm_pins_pull_sel(p_ps), .fault_side_pins_in(q_in), .fault_side_pins_out(q_out),
		.fault_side_pins_oe(q_oe), .fault_pins_low_drive(q_ld), .fault_pins_pull_en(q_pe),
		.fault_pins_pull_sel(q_ps), .serial_side_pins_in(s_in), .serial_side_pins_out(s_out),
		.serial_side_pins_oe(s_oe), .pwm_chan_en(pwm_en), .pwm_chan_out(pwm_out),
		.fault_fn_en(f_en), .fault_inputs(f_in), .current_status_inputs_n(cs_n),
		.spi_en(spi_en), .spi_pin_out(spi_out), .spi_pin_oe(spi_oe), .spi_pin_in(spi_in),
		.serial_b_tx_en(b_txe), .serial_b_rx_en(b_rxe), .serial_b_tx(b_tx),
		.serial_b_rx(b_rx), .serial_a_tx_en(a_txe), .serial_a_rx_en(a_rxe),
		.serial_a_tx(a_tx), .serial_a_rx(a_rx));
	pqs_pin_model #(.W(6)) i_pin_p (.clk(clk), .out(p_out), .oe(p_oe), .pull_en(p_pe),
		.pull_sel(p_ps), .ext_en(p_xe), .ext_val(p_xv), .level(p_in));
	pqs_pin_model #(.W(7)) i_pin_q (.clk(clk), .out(q_out), .oe(q_oe), .pull_en(q_pe),
		.pull_sel(q_ps), .ext_en(q_xe), .ext_val(q_xv), .level(q_in));
	pqs_pin_model #(.W(8)) i_pin_s (.clk(clk), .out(s_out), .oe(s_oe), .pull_en(8'h00),
		.pull_sel(8'h00), .ext_en(s_xe), .ext_val(s_xv), .level(s_in));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic report_and_stop();
		if (n_fail == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
			n_fail++;
		end
	endtask : chk
	// Holds the request until pready is seen high at a rising edge, giving up after 20 edges
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		// Read right after the edge: the values the slave showed at that edge
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			n_fail++;
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		chk(r, exp);
	endtask : rd
	task automatic settle(input int n);
		repeat (n) @(negedge clk);
	endtask : settle
	task automatic t_reset();
		for (int i = 0; i < 4; i++) begin
			rd(8'(P_DIRECTION_OFF + 4 * i), 32'h0);
			rd(8'(Q_DIRECTION_OFF + 4 * i), 32'h0);
		end
		rd(S_DIRECTION_OFF, 32'h0);
		chk(32'({p_oe, q_oe, s_oe}), 32'h0);
	endtask : t_reset
	task automatic t_dir();
		wr(P_DIRECTION_OFF, 32'hffff_ffff);
		rd(P_DIRECTION_OFF, 32'h3f);
		wr(Q_DIRECTION_OFF, 32'hff);
		rd(Q_DIRECTION_OFF, 32'h7f);
		settle(2);
		chk(32'({p_oe, q_oe}), 32'h1fff);
		wr(Q_DIRECTION_OFF, 32'h0);
	endtask : t_dir
	task automatic t_data();
		wr(P_DATA_OFF, 32'h15);
		rd(P_DATA_OFF, 32'h15);
		settle(2);
		chk(32'(p_out), 32'h15);
		wr(P_DIRECTION_OFF, 32'h0);
		p_xe <= 6'h3f;
		p_xv <= 6'h2a;
		settle(8);
		rd(P_DATA_OFF, 32'h2a);
		wr(P_PIN_INPUT_OFF, 32'h00);
		rd(P_PIN_INPUT_OFF, 32'h2a);
		p_xe <= 6'h0;
	endtask : t_data
	task automatic t_pwm();
		pwm_en <= 6'h21;
		pwm_out <= 6'h01;
		settle(2);
		chk(32'(p_oe), 32'h21);
		chk(32'(p_out & 6'h21), 32'h01);
		@(posedge clk);
		pwm_en <= 6'h0;
		settle(2);
		chk(32'(p_oe), 32'h0);
	endtask : t_pwm
	task automatic t_fault();
		wr(Q_DATA_OFF, 32'h33);
		wr(Q_DRIVE_STRENGTH_OFF, 32'h7f);
		wr(Q_DIRECTION_OFF, 32'h7f);
		f_en <= 7'h7f;
		q_xe <= 7'h7f;
		q_xv <= 7'h55;
		settle(8);
		chk(32'({q_ld, q_oe}), 32'h0);
		chk(32'({cs_n, f_in}), 32'h55);
		@(posedge clk);
		q_xe <= 7'h0;
		f_en <= 7'h0;
		settle(2);
		chk(32'({q_ld, q_oe}), 32'h3fff);
		chk(32'(q_out), 32'h33);
		rd(Q_DATA_OFF, 32'h33);
		wr(Q_DIRECTION_OFF, 32'h0);
	endtask : t_fault
	task automatic t_pull();
		wr(P_DIRECTION_OFF, 32'h0f);
		wr(P_DRIVE_STRENGTH_OFF, 32'h3f);
		wr(P_PULL_ENABLE_OFF, 32'h3f);
		wr(P_PULL_POLARITY_OFF, 32'h2a);
		rd(P_PULL_POLARITY_OFF, 32'h2a);
		settle(2);
		chk(32'(p_ld), 32'h0f);
		chk(32'(p_pe), 32'h30);
		chk(32'(p_ps), 32'h20);
		wr(Q_PULL_ENABLE_OFF, 32'h7f);
		settle(8);
		chk(32'({q_pe, q_ps}), 32'h3f80);
		rd(Q_PIN_INPUT_OFF, 32'h7f);
		rd(Q_DATA_OFF, 32'h7f);
		rd(P_PIN_INPUT_OFF, 32'h15);
	endtask : t_pull
	task automatic t_serial();
		wr(S_DIRECTION_OFF, 32'hff);
		spi_en <= 1'b1;
		spi_oe <= 4'hc;
		spi_out <= 4'h8;
		b_txe <= 1'b1;
		b_tx <= 1'b1;
		b_rxe <= 1'b1;
		a_rxe <= 1'b1;
		s_xe <= 8'h35;
		s_xv <= 8'h15;
		settle(8);
		chk(32'(s_oe), 32'hca);
		chk(32'(s_out & 8'hf8), 32'h88);
		chk(32'({spi_in[1:0], b_rx, a_rx}), 32'h7);
		wr(S_DIRECTION_OFF, 32'h0);
		wr(S_DATA_OFF, 32'hf0);
		spi_en <= 1'b0;
		a_txe <= 1'b1;
		a_tx <= 1'b1;
		settle(2);
		chk(32'(s_oe), 32'h0a);
		chk(32'(s_out), 32'hfa);
	endtask : t_serial
	task automatic t_err();
		logic [31:0] r;
		logic e;
		apb(1'b0, 8'hfc, 32'h0, r, e);
		chk({r[30:0], e}, 32'h1);
	endtask : t_err
	initial begin
		n_fail = 0;
		n_compared = 0;
		rst_n = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{pwm_en, pwm_out, p_xe, p_xv, f_en, q_xe, q_xv, s_xe, s_xv} = '0;
		{spi_en, spi_out, spi_oe, b_txe, b_rxe, b_tx, a_txe, a_rxe, a_tx} = '0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_dir();
		t_data();
		t_pwm();
		t_fault();
		t_pull();
		t_serial();
		t_err();
		report_and_stop();
	end
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		report_and_stop();
	end
endmodule : testbench
`default_nettype wire
